// file: rtl/cpi_pkg.sv
/*
  Shared constants and state types for the CO2 sensor pin interface.
  Assumes a single 10 MHz clock and a synchronous, active-high reset.
*/
package cpi_pkg;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int PWM_HZ = 1000;
  localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_HZ;
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam int CAL_AIR_MIN_S = 4;
  localparam int CAL_AIR_MAX_S = 10;
  localparam int CAL_ZERO_MIN_S = 12;
  localparam int BUSY_TIME_MS = 500;
  localparam logic [15:0] CAL_AIR_MIN_MS = 16'(CAL_AIR_MIN_S * 1000);
  localparam logic [15:0] CAL_AIR_MAX_MS = 16'(CAL_AIR_MAX_S * 1000);
  localparam logic [15:0] CAL_ZERO_MIN_MS = 16'(CAL_ZERO_MIN_S * 1000);
  localparam logic [15:0] BUSY_MS = 16'(BUSY_TIME_MS);
  // ==========================================================
  // concentrations in ppm
  localparam logic [15:0] ALARM_TRIG_RST = 16'h03E8;
  localparam logic [15:0] ALARM_REL_RST = 16'h0384;
  localparam int PPM_FULL = 5000;
  localparam logic [17:0] AIR_PPM = 18'h00190;
  localparam logic [17:0] ZERO_PPM = 18'h00000;
  // arbitrary value, not tied to any real part
  localparam logic [31:0] SERIAL_DEFAULT = 32'h5A5A_0001;
  // ==========================================================
  // state
  typedef enum logic [1:0] {
    CPI_CAL_IDLE = 2'h1,
    CPI_CAL_HOLD = 2'h2
  } cpi_cal_e;

  typedef struct packed {
    logic [15:0] trig, rel, raw, corr;
    logic signed [17:0] offset;
    logic alarm, pwm;
    logic [15:0] phase, ms_div;
    logic ms_tick;
    cpi_cal_e cal_st;
    logic [15:0] low_ms, busy_ms;
    logic air, zero, busy, uart, addr_lsb, strap_done, pd, wr_rej, sn_valid;
    logic dp_out, dp_oe_n, sda_rx, rx, scl;
  } cpi_st_s;

  localparam cpi_st_s CPI_ST_RST = '{trig: ALARM_TRIG_RST, rel: ALARM_REL_RST,
    cal_st: CPI_CAL_IDLE, uart: 1'b1, addr_lsb: 1'b1, dp_out: 1'b1,
    rx: 1'b1, scl: 1'b1, sda_rx: 1'b1, default: '0};
endpackage

// file: rtl/cpi_sensor_pins.sv
/*
  Pin-level logic of the CO2 sensor: alarm with hysteresis, 1 kHz PWM, strap
  pins, calibration request timing, busy, shared serial pins, modes, serial no.
  Assumes measurement, UART and I2C engines live outside and talk over ports.
*/
`timescale 1ns/1ps

module cpi_sensor_pins import cpi_pkg::*; #(
  parameter int MS_CYCLES = MS_CYC,
  parameter int PWM_CYCLES = PWM_PERIOD_CYC,
  parameter logic [31:0] SERIAL_NUMBER = SERIAL_DEFAULT
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [15:0] meas_ppm_in,
  input wire logic meas_valid_in,
  input wire logic thr_wr_in,
  input wire logic [15:0] thr_trig_in,
  input wire logic [15:0] thr_rel_in,
  input wire logic pd_req_in,
  input wire logic cont_req_in,
  input wire logic busy_req_in,
  input wire logic sn_req_in,
  input wire logic addr_lsb_select_in,
  input wire logic addr_lsb_select_driven_in,
  input wire logic interface_select_in,
  input wire logic interface_select_driven_in,
  input wire logic cal_req_n_in,
  input wire logic cal_req_driven_in,
  input wire logic tx_data_in,
  input wire logic sda_pull_low_in,
  input wire logic data_pin_in,
  input wire logic clk_pin_in,
  output logic [15:0] conc_out,
  output logic alarm_out,
  output logic pwm_out,
  output logic busy_out,
  output logic addr_lsb_out,
  output logic uart_mode_out,
  output logic pd_mode_out,
  output logic cal_mode_out,
  output logic air_adj_out,
  output logic zero_adj_out,
  output logic wr_reject_out,
  output logic sn_valid_out,
  output logic [31:0] sn_out,
  output logic data_pin_out,
  output logic data_pin_oe_n_out,
  output logic sda_rx_out,
  output logic uart_rx_out,
  output logic scl_out
);
  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);
  localparam logic [15:0] PWM_LAST = 16'(PWM_CYCLES - 1);

  cpi_st_s st_r, st_nxt;
  logic cal_lvl, ifs_lvl, addr_lvl;
  logic signed [17:0] sum;

  function automatic logic in_win(input logic [15:0] v, input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_win = (v >= lo) && (v <= hi);
  endfunction

  // ==========================================================
  // pull-ups: an undriven strap reads High
  assign cal_lvl = cal_req_driven_in ? cal_req_n_in : 1'b1;
  assign ifs_lvl = interface_select_driven_in ? interface_select_in : 1'b1;
  assign addr_lvl = addr_lsb_select_driven_in ? addr_lsb_select_in : 1'b1;
  assign sum = $signed({2'h0, st_r.raw}) + st_r.offset;

  // ==========================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.air = 1'b0;
    st_nxt.zero = 1'b0;
    st_nxt.wr_rej = 1'b0;
    st_nxt.sn_valid = 1'b0;
    st_nxt.ms_tick = 1'b0;
    // straps are caught once, on the first cycle after reset release
    if (!st_r.strap_done) begin
      st_nxt.strap_done = 1'b1;
      st_nxt.uart = ifs_lvl;
      st_nxt.addr_lsb = addr_lvl;
    end
    if (meas_valid_in) begin
      st_nxt.raw = meas_ppm_in;
    end
    // corrected concentration, clamped to the 16-bit range
    if (sum < 0) begin
      st_nxt.corr = 16'h0000;
    end else if (sum > 18'sh0FFFF) begin
      st_nxt.corr = 16'hFFFF;
    end else begin
      st_nxt.corr = sum[15:0];
    end
    // I2C writes are only honoured in power-down; UART writes always
    if (thr_wr_in) begin
      if (st_r.uart || st_r.pd) begin
        st_nxt.trig = thr_trig_in;
        st_nxt.rel = thr_rel_in;
      end else begin
        st_nxt.wr_rej = 1'b1;
      end
    end
    if (st_r.corr >= st_r.trig) begin
      st_nxt.alarm = 1'b1;
    end else if (st_r.corr < st_r.rel) begin
      st_nxt.alarm = 1'b0;
    end
    st_nxt.phase = (st_r.phase >= PWM_LAST) ? 16'h0000 : st_r.phase + 16'h0001;
    st_nxt.pwm = (32'(st_r.phase) * 32'(PPM_FULL)) <
                 (32'(st_r.corr) * 32'(PWM_CYCLES));
    if (st_r.ms_div >= MS_LAST) begin
      st_nxt.ms_div = 16'h0000;
      st_nxt.ms_tick = 1'b1;
    end else begin
      st_nxt.ms_div = st_r.ms_div + 16'h0001;
    end
    // judged on release so a long hold never fires air then zero
    case (st_r.cal_st)
      CPI_CAL_IDLE: begin
        if (!cal_lvl) begin
          st_nxt.cal_st = CPI_CAL_HOLD;
          st_nxt.low_ms = 16'h0000;
        end
      end
      CPI_CAL_HOLD: begin
        if (cal_lvl) begin
          st_nxt.cal_st = CPI_CAL_IDLE;
          if (in_win(st_r.low_ms, CAL_AIR_MIN_MS, CAL_AIR_MAX_MS)) begin
            st_nxt.air = 1'b1;
            st_nxt.offset = $signed(AIR_PPM) - $signed({2'h0, st_r.raw});
          end else if (in_win(st_r.low_ms, CAL_ZERO_MIN_MS, 16'hFFFF)) begin
            st_nxt.zero = 1'b1;
            st_nxt.offset = $signed(ZERO_PPM) - $signed({2'h0, st_r.raw});
          end
          // any other hold length leaves the offset alone
        end else if (st_r.ms_tick && st_r.low_ms != 16'hFFFF) begin
          st_nxt.low_ms = st_r.low_ms + 16'h0001;
        end
      end
      default: begin
        st_nxt.cal_st = CPI_CAL_IDLE;
      end
    endcase
    // adjustment is internal processing, so it also raises busy
    if (busy_req_in || st_r.air || st_r.zero) begin
      st_nxt.busy = 1'b1;
      st_nxt.busy_ms = 16'h0000;
    end else if (st_r.busy && st_r.ms_tick) begin
      if (st_r.busy_ms >= BUSY_MS - 16'h0001) begin
        st_nxt.busy = 1'b0;
      end else begin
        st_nxt.busy_ms = st_r.busy_ms + 16'h0001;
      end
    end
    if (pd_req_in && !cont_req_in) begin
      st_nxt.pd = 1'b1;
    end else if (cont_req_in && !pd_req_in) begin
      st_nxt.pd = 1'b0;
    end
    st_nxt.sn_valid = sn_req_in;
    // shared pins
    st_nxt.dp_out = st_r.uart ? tx_data_in : 1'b0;
    st_nxt.dp_oe_n = st_r.uart ? 1'b0 : !sda_pull_low_in;
    st_nxt.sda_rx = st_r.uart ? 1'b1 : data_pin_in;
    st_nxt.rx = st_r.uart ? clk_pin_in : 1'b1;
    st_nxt.scl = st_r.uart ? 1'b1 : clk_pin_in;
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      st_r <= CPI_ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign conc_out = st_r.corr;
  assign alarm_out = st_r.alarm;
  assign pwm_out = st_r.pwm;
  assign busy_out = st_r.busy;
  assign addr_lsb_out = st_r.addr_lsb;
  assign uart_mode_out = st_r.uart;
  assign pd_mode_out = st_r.pd;
  assign cal_mode_out = st_r.cal_st[1];
  assign air_adj_out = st_r.air;
  assign zero_adj_out = st_r.zero;
  assign wr_reject_out = st_r.wr_rej;
  assign sn_valid_out = st_r.sn_valid;
  assign sn_out = SERIAL_NUMBER;
  assign data_pin_out = st_r.dp_out;
  assign data_pin_oe_n_out = st_r.dp_oe_n;
  assign sda_rx_out = st_r.sda_rx;
  assign uart_rx_out = st_r.rx;
  assign scl_out = st_r.scl;

  // ==========================================================
  // checks
  alarm_set_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    st_r.corr >= st_r.trig |=> alarm_out) else $error("alarm not raised at trigger");
  alarm_hyst_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    st_r.corr < st_r.trig && st_r.corr >= st_r.rel |=> $stable(alarm_out))
    else $error("alarm moved inside hysteresis band");
  alarm_clr_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    st_r.corr < st_r.rel && st_r.corr < st_r.trig |=> !alarm_out)
    else $error("alarm not released");
  thr_write_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    thr_wr_in && (st_r.uart || st_r.pd) |=> st_r.trig == $past(thr_trig_in)
      && st_r.rel == $past(thr_rel_in)) else $error("threshold write lost");
  pwm_wrap_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    st_r.phase == PWM_LAST |=> st_r.phase == 16'h0000) else $error("pwm period wrong");
  pwm_ends_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (st_r.corr == 16'h0000 |=> !pwm_out) and (st_r.corr >= 16'(PPM_FULL) |=> pwm_out))
    else $error("pwm duty end point wrong");
  strap_hold_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    st_r.strap_done |=> $stable(uart_mode_out) && $stable(addr_lsb_out))
    else $error("strap changed after reset");
  air_adj_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    st_r.cal_st == CPI_CAL_HOLD && cal_lvl
      && in_win(st_r.low_ms, CAL_AIR_MIN_MS, CAL_AIR_MAX_MS)
      |=> air_adj_out && !zero_adj_out
      ##1 (conc_out == 16'(AIR_PPM) || $past(meas_valid_in, 2)))
    else $error("air adjust missing");
  zero_adj_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    st_r.cal_st == CPI_CAL_HOLD && cal_lvl && st_r.low_ms >= CAL_ZERO_MIN_MS
      |=> zero_adj_out && !air_adj_out) else $error("zero adjust missing");
  no_adj_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    st_r.cal_st == CPI_CAL_HOLD && cal_lvl && (st_r.low_ms < CAL_AIR_MIN_MS
      || (st_r.low_ms > CAL_AIR_MAX_MS && st_r.low_ms < CAL_ZERO_MIN_MS))
      |=> !air_adj_out && !zero_adj_out) else $error("unexpected adjustment");
  busy_start_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    busy_req_in |=> busy_out [*2]) else $error("busy not raised");
  pin_route_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    st_r.uart |=> !data_pin_oe_n_out && sda_rx_out) else $error("tx pin not driven");
  scl_route_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !st_r.uart |=> uart_rx_out && scl_out == $past(clk_pin_in))
    else $error("scl routing wrong");
  pd_mode_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    pd_req_in && !cont_req_in |=> pd_mode_out) else $error("power down not entered");
  sn_read_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    sn_req_in |=> sn_valid_out && sn_out == SERIAL_NUMBER) else $error("serial not sent");
  sn_pulse_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !sn_req_in |=> !sn_valid_out) else $error("serial valid without request");

  // ==========================================================
  // strap, pin, mode, write-reject and busy checks
  // sampled reset in an antecedent keeps the release edge out of the checks that have it
  strap_mode_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !reset_in && !st_r.strap_done |=> uart_mode_out
      == $past(!interface_select_driven_in || interface_select_in))
    else $error("interface strap not taken");
  addr_strap_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !reset_in && !st_r.strap_done |=> addr_lsb_out
      == $past(!addr_lsb_select_driven_in || addr_lsb_select_in))
    else $error("address strap not taken");
  cal_enter_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !reset_in && st_r.cal_st == CPI_CAL_IDLE && cal_req_driven_in && !cal_req_n_in
      |=> cal_mode_out) else $error("calibration mode not entered");
  wr_reject_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    thr_wr_in && !st_r.uart && !st_r.pd |=> wr_reject_out
      && st_r.trig == $past(st_r.trig) && st_r.rel == $past(st_r.rel))
    else $error("threshold write not refused");
  i2c_pin_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !reset_in && !st_r.uart |=> !data_pin_out && sda_rx_out == $past(data_pin_in)
      && data_pin_oe_n_out == $past(!sda_pull_low_in)) else $error("sda routing wrong");
  rx_route_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !reset_in && st_r.uart |=> scl_out && uart_rx_out == $past(clk_pin_in))
    else $error("rx routing wrong");
  cont_mode_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    cont_req_in && !pd_req_in |=> !pd_mode_out) else $error("continuous mode not entered");
  pd_hold_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !reset_in && !pd_req_in && !cont_req_in |=> $stable(pd_mode_out))
    else $error("mode changed without request");
  busy_end_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !busy_req_in && !st_r.air && !st_r.zero && st_r.busy_ms == BUSY_MS - 16'h0001
      && st_r.ms_tick |=> !busy_out) else $error("busy held too long");
endmodule

// file: testbench/cpi_host_model.sv
/*
  Host side of the sensor pins: open-drain data line with pull-up, Rx/SCL driver, busy watch.
  Assumes the bench sets the host's intent bits at clock edges.
*/
`timescale 1ns/1ps
module cpi_host_model (
  input wire logic dev_data_in,
  input wire logic dev_oe_n_in,
  input wire logic host_sda_low_in,
  input wire logic host_clk_in,
  input wire logic busy_in,
  output logic data_pin_out,
  output logic clk_pin_out,
  output logic may_talk_out
);
  // ==========================================================
  // wire resolution
  // pull-up wins when nobody drives; the host can only pull low
  assign data_pin_out = (dev_oe_n_in ? 1'b1 : dev_data_in) & ~host_sda_low_in;
  assign clk_pin_out = host_clk_in;
  assign may_talk_out = ~busy_in;
endmodule

// file: testbench/tb.sv
/*
  Self-checking bench for the sensor pin block beside a host pin model.
  Assumes short tick and PWM periods so that all calibration holds fit one run.
*/
`timescale 1ns/1ps
module tb import cpi_pkg::*;;
  localparam int MSC = 4;
  localparam int PWC = 20;
  typedef struct {logic wr; logic [15:0] ppm; logic al;} cpi_row_s;
  logic clk, rst = 1'b1, mv = 1'b0, al, pwm, busy, adr, uart, pd, calm, air, zero, rej, snv;
  logic [4:0] req = 5'h00;
  logic [15:0] ppm = 16'h0000, conc;
  logic [31:0] sn;
  logic adr_in = 1'b0, adr_drv = 1'b0, ifs_in = 1'b0, ifs_drv = 1'b0, cal_drv = 1'b0;
  logic tx = 1'b1, sda_pull = 1'b0, h_sda_low = 1'b0, h_clk = 1'b1, cal_n = 1'b1;
  logic dpo, oe_n, sda_rx, urx, scl, dpin, cpin, may_talk;
  int n_errors = 0, n_compared = 0, n_air = 0, n_zero = 0, hi, e;
  cpi_row_s rows[11] = '{'{1'b0, 16'h01F4, 1'b0}, '{1'b0, 16'h03E8, 1'b1},
    '{1'b0, 16'h03B6, 1'b1}, '{1'b0, 16'h0383, 1'b0}, '{1'b0, 16'h03E7, 1'b0},
    '{1'b0, 16'h1770, 1'b1}, '{1'b0, 16'h0000, 1'b0}, '{1'b1, 16'h07CF, 1'b0},
    '{1'b0, 16'h07D0, 1'b1}, '{1'b0, 16'h05DC, 1'b1}, '{1'b0, 16'h05DB, 1'b0}};

  // ==========================================================
  // design and host
  // the calibration pin is open unless cal_drv is set; open, it reads High by its pull-up
  cpi_sensor_pins #(.MS_CYCLES(MSC), .PWM_CYCLES(PWC)) dut (.sys_clk_in(clk), .reset_in(rst),
    .meas_ppm_in(ppm), .meas_valid_in(mv), .thr_wr_in(req[0]), .thr_trig_in(16'h07D0),
    .thr_rel_in(16'h05DC), .pd_req_in(req[1]), .cont_req_in(req[2]), .busy_req_in(req[3]),
    .sn_req_in(req[4]), .addr_lsb_select_in(adr_in), .addr_lsb_select_driven_in(adr_drv),
    .interface_select_in(ifs_in), .interface_select_driven_in(ifs_drv),
    .cal_req_n_in(cal_n), .cal_req_driven_in(cal_drv), .tx_data_in(tx),
    .sda_pull_low_in(sda_pull), .data_pin_in(dpin), .clk_pin_in(cpin), .conc_out(conc),
    .alarm_out(al), .pwm_out(pwm), .busy_out(busy), .addr_lsb_out(adr), .uart_mode_out(uart),
    .pd_mode_out(pd), .cal_mode_out(calm), .air_adj_out(air), .zero_adj_out(zero),
    .wr_reject_out(rej), .sn_valid_out(snv), .sn_out(sn), .data_pin_out(dpo),
    .data_pin_oe_n_out(oe_n), .sda_rx_out(sda_rx), .uart_rx_out(urx), .scl_out(scl));
  cpi_host_model host (.dev_data_in(dpo), .dev_oe_n_in(oe_n), .host_sda_low_in(h_sda_low),
    .host_clk_in(h_clk), .busy_in(busy), .data_pin_out(dpin), .clk_pin_out(cpin),
    .may_talk_out(may_talk));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    n_air += (air === 1'b1);
    n_zero += (zero === 1'b1);
  end

  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    n_compared++;
    if (g !== ex) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, ex, g);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic strobe(input logic [4:0] r);
    @(posedge clk);
    req <= r;
    @(posedge clk);
    req <= 5'h00;
    #1;
  endtask
  task automatic meas(input logic [15:0] p);
    @(posedge clk);
    ppm <= p;
    mv <= 1'b1;
    @(posedge clk);
    mv <= 1'b0;
    w(4);
  endtask
  // straps need one edge, the pin routing one more and the SDA echo one more before the pins settle
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    w(5);
  endtask
  task automatic cal(input int ms);
    @(posedge clk);
    cal_drv <= 1'b1;
    cal_n <= 1'b0;
    w(3);
    chk("cal_mode", 1, calm);
    repeat (ms * MSC - 3) @(posedge clk);
    cal_drv <= 1'b0;
    cal_n <= 1'b1;
    w(6);
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    do_reset;
    chk("reset_state", 32'h03, {busy, al, pd, calm, uart, adr});
    foreach (rows[i]) begin
      if (rows[i].wr) strobe(5'h01);
      meas(rows[i].ppm);
      chk("conc", rows[i].ppm, conc);
      chk("alarm", rows[i].al, al);
      hi = 0;
      repeat (PWC) begin
        @(posedge clk);
        #1;
        hi += (pwm === 1'b1);
      end
      e = (int'(rows[i].ppm) * PWC + 4999) / 5000;
      if (e > PWC) e = PWC;
      chk("pwm_high", e, hi);
    end
    @(posedge clk);
    tx <= 1'b0;
    h_clk <= 1'b0;
    w(3);
    chk("uart_pins", 32'h03, {dpo, oe_n, urx, scl, sda_rx});
    @(posedge clk);
    tx <= 1'b1;
    h_clk <= 1'b1;
    strobe(5'h10);
    chk("sn_valid", 1, snv);
    chk("sn", SERIAL_DEFAULT, sn);
    strobe(5'h08);
    chk("busy", 32'h01, {may_talk, busy});
    w(1990);
    chk("busy_hold", 1, busy);
    w(20);
    chk("busy_end", 0, busy);
    @(posedge clk);
    cal_drv <= 1'b1;
    w(40);
    chk("cal_held_high", 0, {calm, air, zero});
    @(posedge clk);
    cal_drv <= 1'b0;
    cal(4100);
    chk("air_count", 1, n_air);
    chk("air_conc", 16'h0190, conc);
    chk("adj_busy", 1, busy);
    cal(12100);
    chk("zero_count", 1, n_zero);
    chk("zero_conc", 0, conc);
    cal(3900);
    chk("short_hold", 2, n_air + n_zero);
    @(posedge clk);
    ifs_drv <= 1'b1;
    adr_drv <= 1'b1;
    sda_pull <= 1'b1;
    h_clk <= 1'b0;
    do_reset;
    chk("i2c_straps", 0, {uart, adr});
    chk("sda_low", 32'h01, {dpo, oe_n, sda_rx, scl, urx});
    @(posedge clk);
    ifs_in <= 1'b1;
    sda_pull <= 1'b0;
    h_sda_low <= 1'b1;
    h_clk <= 1'b1;
    w(3);
    chk("sda_host", 32'h05, {uart, oe_n, sda_rx, scl});
    wait (may_talk === 1'b1);
    @(posedge clk);
    h_sda_low <= 1'b0;
    strobe(5'h01);
    chk("reject", 1, rej);
    meas(16'h07CF);
    chk("kept_trig", 1, al);
    strobe(5'h02);
    chk("pd_mode", 1, pd);
    strobe(5'h01);
    chk("accept", 0, rej);
    meas(16'h05DB);
    chk("new_rel", 0, al);
    strobe(5'h04);
    chk("cont_mode", 0, pd);
    end_of_test;
  end

  // about 83k cycles are needed; cut the run at 100k
  initial begin
    #10_000_000;
    n_errors++;
    end_of_test;
  end
endmodule
